// ### logic/sadc_pkg.sv
package sadc_pkg;

    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int SEL_W  = 4;
    localparam int IDX_W  = 16;
    localparam int RES_W  = 12;
    localparam int NUM_CH = 2;
    localparam int IRQ_W  = 3;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_RES0_LOW   = 16'hF2D0;
    localparam logic [15:0] IDX_RES0_HIGH  = 16'hF2D1;
    localparam logic [15:0] IDX_RES1_LOW   = 16'hF2D2;
    localparam logic [15:0] IDX_RES1_HIGH  = 16'hF2D3;
    localparam logic [15:0] IDX_CTRL_ZERO  = 16'hF2F0;
    localparam logic [15:0] IDX_CTRL_ONE   = 16'hF2F1;
    localparam logic [15:0] IDX_CHAN_SEL   = 16'hF2F2;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hF2F8;
    localparam logic [15:0] IDX_IRQ_MASK   = 16'hF2F9;

    localparam logic [7:0]  RES_RST        = 8'h00;
    localparam logic [7:0]  CTRL_ZERO_RST  = 8'h02;
    localparam logic [7:0]  CTRL_ONE_RST   = 8'h00;
    localparam logic [7:0]  CHAN_SEL_RST   = 8'h00;
    localparam logic [2:0]  IRQ_RST        = 3'h0;

    localparam int LOOP_SELECT_BIT = 0;
    localparam int RUN_BIT         = 0;
    localparam int EN_CH0_BIT      = 0;
    localparam int EN_CH1_BIT      = 1;
    localparam int IRQ_DONE_BIT    = 0;
    localparam int IRQ_CH0_BIT     = 1;
    localparam int IRQ_CH1_BIT     = 2;
    localparam int LOW_NIB_POS     = 4;

    localparam int CLK_MHZ      = 20;
    localparam int CONV_TIME_NS = 46000;
    localparam int CONV_CYCLES  = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_CNT_W   = 10;
    localparam logic [9:0] CONV_LAST = 10'(CONV_CYCLES - 1);

    typedef enum logic [1:0] {
        S_IDLE,
        S_CONV,
        S_EMPTY
    } sadc_state_t;

endpackage

// ### logic/sadc_control.sv
// Notes on behaviour
// - Sequencer gives 12-bit results, two selectable channels
// - Low byte: result 3..0 in 7..4
// - High byte: result 11..4 in 7..0
// - Channel zero F2D0/F2D1, channel one F2D2/F2D3
// - Results read-only, reset zero, own-channel update
// - Low result address readable as byte or word
// - Loop select zero: one pass per start
// - Loop select one: convert selected channels repeatedly
// - Control zero at F2F0, byte/word, reset 02
// - Control one at F2F1, byte, run bit 0
// - Channel select at F2F2, byte, reset 00
// - Run one starts, zero stops, single pass self-clears
// - Both enabled: channel zero, then channel one
// - Done interrupt after highest selected channel completes
// - Selection captured at start until done interrupt
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none

module sadc_control (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [17:0] adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             irq_o,
    output logic             conv_start_o,
    output logic             conv_channel_o,
    output logic             conv_busy_o,
    input  wire logic [11:0] comp_result_i
);

    function automatic logic [7:0] low_byte(input logic [11:0] r);
        low_byte = {r[3:0], 4'h0};
    endfunction

    function automatic logic [7:0] high_byte(input logic [11:0] r);
        high_byte = r[11:4];
    endfunction

    function automatic logic [31:0] low_read(input logic [11:0] r,
                                             input logic       wide);
        if (wide) begin
            low_read = {16'h0000, high_byte(r), low_byte(r)};
        end else begin
            low_read = {24'h000000, low_byte(r)};
        end
    endfunction

    logic               ack_reg;
    logic               ack_next;
    logic [31:0]        dat_reg;
    logic [31:0]        dat_next;
    logic [7:0]         ctrl0_reg;
    logic [7:0]         ctrl0_next;
    logic [7:0]         ctrl1_reg;
    logic [7:0]         ctrl1_next;
    logic [7:0]         chsel_reg;
    logic [7:0]         chsel_next;

    // Results, one entry per channel
    logic [11:0]        res_reg  [2];
    logic [11:0]        res_next [2];
    logic [2:0]         status_reg;
    logic [2:0]         status_next;
    logic [2:0]         mask_reg;
    logic [2:0]         mask_next;
    logic               irq_reg;
    logic               irq_next;

    // Sequencer state
    sadc_pkg::sadc_state_t state_reg;
    sadc_pkg::sadc_state_t state_next;
    logic [1:0]         latch_reg;
    logic [1:0]         latch_next;
    logic               ch_reg;
    logic               ch_next;
    logic [9:0]         cnt_reg;
    logic [9:0]         cnt_next;
    logic               start_reg;
    logic               start_next;

    // Bus decode and strobes shared between groups
    logic               hit;
    logic               wr;
    logic               rd;
    logic [15:0]        idx;
    logic               run;
    logic               loop_sel;
    logic [2:0]         ev_set;
    logic [2:0]         rd_clr;
    logic               hw_run_clr;

    assign hit      = cyc_i & stb_i & ~ack_reg;
    assign wr       = hit & we_i;
    assign rd       = hit & ~we_i;
    assign idx      = adr_i[17:2];
    assign run      = ctrl1_reg[sadc_pkg::RUN_BIT];
    assign loop_sel = ctrl0_reg[sadc_pkg::LOOP_SELECT_BIT];

    // Sequencer
    always_comb begin
        state_next = state_reg;
        latch_next = latch_reg;
        ch_next    = ch_reg;
        cnt_next   = cnt_reg;
        start_next = 1'b0;
        res_next   = res_reg;
        ev_set     = 3'h0;
        hw_run_clr = 1'b0;
        case (state_reg)
            sadc_pkg::S_IDLE: begin
                if (run) begin
                    // Selection frozen for the whole pass
                    latch_next = chsel_reg[1:0];
                    cnt_next   = 10'h000;
                    if (chsel_reg[1:0] == 2'h0) begin
                        // No channel: sits active, nothing happens
                        state_next = sadc_pkg::S_EMPTY;
                    end else begin
                        // Lowest selected channel first
                        ch_next    = ~chsel_reg[sadc_pkg::EN_CH0_BIT];
                        start_next = 1'b1;
                        state_next = sadc_pkg::S_CONV;
                    end
                end
            end
            sadc_pkg::S_CONV: begin
                if (!run) begin
                    // Abort discards the conversion in progress
                    state_next = sadc_pkg::S_IDLE;
                end else if (cnt_reg == sadc_pkg::CONV_LAST) begin
                    res_next[ch_reg] = comp_result_i;
                    ev_set[ch_reg ? sadc_pkg::IRQ_CH1_BIT
                                  : sadc_pkg::IRQ_CH0_BIT] = 1'b1;
                    cnt_next = 10'h000;
                    if (ch_reg || !latch_reg[sadc_pkg::EN_CH1_BIT]) begin
                        ev_set[sadc_pkg::IRQ_DONE_BIT] = 1'b1;
                        if (loop_sel) begin
                            latch_next = chsel_reg[1:0];
                            if (chsel_reg[1:0] == 2'h0) begin
                                state_next = sadc_pkg::S_EMPTY;
                            end else begin
                                ch_next    = ~chsel_reg[sadc_pkg::EN_CH0_BIT];
                                start_next = 1'b1;
                            end
                        end else begin
                            hw_run_clr = 1'b1;
                            state_next = sadc_pkg::S_IDLE;
                        end
                    end else begin
                        ch_next    = 1'b1;
                        start_next = 1'b1;
                    end
                end else begin
                    cnt_next = cnt_reg + 10'h001;
                end
            end
            sadc_pkg::S_EMPTY: begin
                // Run stays set: no result, no interrupt, no self-clear
                if (!run) begin
                    state_next = sadc_pkg::S_IDLE;
                end
            end
            default: begin
                state_next = sadc_pkg::S_IDLE;
            end
        endcase
    end

    // Control registers
    always_comb begin
        ctrl0_next = ctrl0_reg;
        ctrl1_next = ctrl1_reg;
        chsel_next = chsel_reg;
        mask_next  = mask_reg;
        if (hw_run_clr) begin
            ctrl1_next[sadc_pkg::RUN_BIT] = 1'b0;
        end
        // Software write applied after the self-clear so it wins
        if (wr) begin
            case (idx)
                sadc_pkg::IDX_CTRL_ZERO: begin
                    if (sel_i[0]) begin
                        ctrl0_next = dat_i[7:0];
                    end
                    if (sel_i[1]) begin
                        ctrl1_next = dat_i[15:8];
                    end
                end
                sadc_pkg::IDX_CTRL_ONE: begin
                    if (sel_i[0]) begin
                        ctrl1_next = dat_i[7:0];
                    end
                end
                sadc_pkg::IDX_CHAN_SEL: begin
                    if (sel_i[0]) begin
                        chsel_next = dat_i[7:0];
                    end
                end
                sadc_pkg::IDX_IRQ_MASK: begin
                    if (sel_i[0]) begin
                        mask_next = dat_i[2:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Bus answer and clearing reads
    always_comb begin
        ack_next = hit;
        dat_next = dat_reg;
        rd_clr   = 3'h0;
        if (rd) begin
            case (idx)
                sadc_pkg::IDX_RES0_LOW: begin
                    dat_next = low_read(res_reg[0], sel_i[1]);
                end
                sadc_pkg::IDX_RES0_HIGH: begin
                    dat_next = {24'h000000, high_byte(res_reg[0])};
                end
                sadc_pkg::IDX_RES1_LOW: begin
                    dat_next = low_read(res_reg[1], sel_i[1]);
                end
                sadc_pkg::IDX_RES1_HIGH: begin
                    dat_next = {24'h000000, high_byte(res_reg[1])};
                end
                sadc_pkg::IDX_CTRL_ZERO: begin
                    if (sel_i[1]) begin
                        dat_next = {16'h0000, ctrl1_reg, ctrl0_reg};
                    end else begin
                        dat_next = {24'h000000, ctrl0_reg};
                    end
                end
                sadc_pkg::IDX_CTRL_ONE: begin
                    dat_next = {24'h000000, ctrl1_reg};
                end
                sadc_pkg::IDX_CHAN_SEL: begin
                    dat_next = {24'h000000, chsel_reg};
                end
                sadc_pkg::IDX_IRQ_STATUS: begin
                    dat_next = {29'h00000000, status_reg};
                    rd_clr   = 3'h7;
                end
                sadc_pkg::IDX_IRQ_MASK: begin
                    dat_next = {29'h00000000, mask_reg};
                end
                default: begin
                    dat_next = 32'h00000000;
                end
            endcase
        end
    end

    // Interrupt group; a new event beats a clearing read in one cycle
    always_comb begin
        status_next = (status_reg & ~rd_clr) | ev_set;
        irq_next    = |(status_next & mask_next);
    end

    // Bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    // Control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl0_reg <= sadc_pkg::CTRL_ZERO_RST;
            ctrl1_reg <= sadc_pkg::CTRL_ONE_RST;
            chsel_reg <= sadc_pkg::CHAN_SEL_RST;
            mask_reg  <= sadc_pkg::IRQ_RST;
        end else begin
            ctrl0_reg <= ctrl0_next;
            ctrl1_reg <= ctrl1_next;
            chsel_reg <= chsel_next;
            mask_reg  <= mask_next;
        end
    end

    // Interrupt status and level output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= sadc_pkg::IRQ_RST;
            irq_reg    <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq_reg    <= irq_next;
        end
    end

    // Sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= sadc_pkg::S_IDLE;
            latch_reg <= 2'h0;
            ch_reg    <= 1'b0;
            cnt_reg   <= 10'h000;
            start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            latch_reg <= latch_next;
            ch_reg    <= ch_next;
            cnt_reg   <= cnt_next;
            start_reg <= start_next;
        end
    end

    // One holder per channel; only its own completion writes it
    for (genvar g = 0; g < sadc_pkg::NUM_CH; g++) begin : g_res
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                res_reg[g] <= 12'h000;
            end else begin
                res_reg[g] <= res_next[g];
            end
        end
    end

    assign dat_o          = dat_reg;
    assign ack_o          = ack_reg;
    assign irq_o          = irq_reg;
    assign conv_start_o   = start_reg;
    assign conv_channel_o = ch_reg;
    assign conv_busy_o    = (state_reg == sadc_pkg::S_CONV);

endmodule

`default_nettype wire

// ### testbench/sadc_control_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module sadc_control_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [17:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic        we_i,
    input wire logic [3:0]  sel_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        conv_start_o,
    input wire logic        conv_channel_o,
    input wire logic        conv_busy_o
);
    logic [9:0] gap_reg;
    logic [9:0] gap_next;
    // Parked at the top while idle, so an aborted pass never looks short
    always_comb begin
        gap_next = gap_reg;
        if (conv_start_o) begin
            gap_next = 10'h001;
        end else if (!conv_busy_o) begin
            gap_next = 10'h3FF;
        end else if (gap_reg != 10'h3FF) begin
            gap_next = gap_reg + 10'h001;
        end
    end
    always_ff @(posedge clk_i) gap_reg <= rst_i ? 10'h3FF : gap_next;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_stop;
        s_req ##0 (we_i && sel_i[0] && !dat_i[0]
            && adr_i == {sadc_pkg::IDX_CTRL_ONE, 2'b00});
    endsequence
    a_ack_follows: assert property (s_req |=> ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_no_stray_ack: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    a_dat_held: assert property (!ack_o |-> $stable(dat_o))
        else $error("read data moved without ack");
    a_start_pulse: assert property (
        conv_start_o |=> !conv_start_o && conv_busy_o)
        else $error("start pulse malformed");
    a_conv_gap: assert property (
        conv_start_o |-> gap_reg >= 10'(sadc_pkg::CONV_CYCLES))
        else $error("conversion shorter than fixed time");
    a_stop_idle: assert property (
        s_stop |-> ##[1:3] !conv_busy_o)
        else $error("run cleared but still busy");
    a_chan_hold: assert property (
        conv_busy_o && !conv_start_o |-> $stable(conv_channel_o))
        else $error("channel moved mid conversion");
endmodule
bind sadc_control sadc_control_asserts i_sadc_control_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .dat_o(dat_o), .ack_o(ack_o), .conv_start_o(conv_start_o),
    .conv_channel_o(conv_channel_o), .conv_busy_o(conv_busy_o));
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [17:0] adr_i = '0;
    logic [31:0] dat_i = '0;
    logic        we_i = 1'b0;
    logic [3:0]  sel_i = '0;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic [11:0] comp_result_i = '0;
    logic [31:0] dat_o;
    logic        ack_o, irq_o, conv_start_o, conv_channel_o, conv_busy_o;
    logic [31:0] seed = 32'h976C;
    logic [11:0] v0, v1;
    logic [31:0] exp_q[$];
    int          miscompares = 0;
    int          checked = 0;
    always #25 clk_i = ~clk_i;
    sadc_control i_sadc_control (.clk_i(clk_i), .rst_i(rst_i),
        .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i), .sel_i(sel_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
        .irq_o(irq_o), .conv_start_o(conv_start_o),
        .conv_channel_o(conv_channel_o), .conv_busy_o(conv_busy_o),
        .comp_result_i(comp_result_i));
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wb(input logic [15:0] idx, input logic w,
                      input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        adr_i <= {idx, 2'b00};
        we_i <= w;
        dat_i <= d;
        sel_i <= s;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    task automatic rd(input logic [15:0] idx, input logic [3:0] s,
                      input logic [31:0] e);
        exp_q.push_back(e);
        wb(idx, 1'b0, 32'h0, s);
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq_o !== 1'b1 && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 5000) begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    // Far side answers per channel so a swapped channel shows up
    always @(posedge clk_i) comp_result_i <= conv_channel_o ? v1 : v0;
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            if (exp_q.size() > 0) chk(dat_o, exp_q.pop_front());
            else miscompares++;
        end
    end
    initial begin
        v0 = 12'h0;
        v1 = 12'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        seed = xorshift(seed);
        v0 = seed[11:0];
        seed = xorshift(seed);
        v1 = seed[11:0];
        rd(sadc_pkg::IDX_CTRL_ZERO, 4'h1, 32'h02);
        rd(sadc_pkg::IDX_CTRL_ONE, 4'h1, 32'h00);
        rd(sadc_pkg::IDX_CHAN_SEL, 4'h1, 32'h00);
        rd(sadc_pkg::IDX_RES0_LOW, 4'h3, 32'h00);
        wb(sadc_pkg::IDX_RES1_HIGH, 1'b1, 32'hFF, 4'h1);
        rd(sadc_pkg::IDX_RES1_HIGH, 4'h1, 32'h00);
        rd(16'hF2E0, 4'h1, 32'h00);
        wb(sadc_pkg::IDX_IRQ_MASK, 1'b1, 32'h01, 4'h1);
        rd(sadc_pkg::IDX_IRQ_MASK, 4'h1, 32'h01);
        wb(sadc_pkg::IDX_CHAN_SEL, 1'b1, 32'h03, 4'h1);
        wb(sadc_pkg::IDX_CTRL_ONE, 1'b1, 32'h01, 4'h1);
        wb(sadc_pkg::IDX_CHAN_SEL, 1'b1, 32'h00, 4'h1);
        wait_irq();
        rd(sadc_pkg::IDX_IRQ_STATUS, 4'h1, 32'h07);
        @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        rd(sadc_pkg::IDX_CTRL_ONE, 4'h1, 32'h00);
        rd(sadc_pkg::IDX_RES0_LOW, 4'h1,
           {24'h0, v0[3:0], 4'h0});
        rd(sadc_pkg::IDX_RES0_HIGH, 4'h1, {24'h0, v0[11:4]});
        rd(sadc_pkg::IDX_RES0_LOW, 4'h3, {16'h0, v0, 4'h0});
        rd(sadc_pkg::IDX_RES1_LOW, 4'h3, {16'h0, v1, 4'h0});
        // Loop mode, channel zero only; loop select set while stopped
        wb(sadc_pkg::IDX_CHAN_SEL, 1'b1, 32'h01, 4'h1);
        wb(sadc_pkg::IDX_CTRL_ZERO, 1'b1, 32'h03, 4'h1);
        rd(sadc_pkg::IDX_CTRL_ZERO, 4'h1, 32'h03);
        wb(sadc_pkg::IDX_CTRL_ONE, 1'b1, 32'h01, 4'h1);
        wait_irq();
        rd(sadc_pkg::IDX_IRQ_STATUS, 4'h1, 32'h03);
        seed = xorshift(seed);
        v0 = seed[11:0];
        wait_irq();
        rd(sadc_pkg::IDX_IRQ_STATUS, 4'h1, 32'h03);
        wb(sadc_pkg::IDX_CTRL_ONE, 1'b1, 32'h00, 4'h1);
        rd(sadc_pkg::IDX_RES0_HIGH, 4'h1, {24'h0, v0[11:4]});
        rd(sadc_pkg::IDX_RES1_LOW, 4'h3, {16'h0, v1, 4'h0});
        rd(sadc_pkg::IDX_CTRL_ONE, 4'h1, 32'h00);
        // Word access to the control pair; loop select back to zero
        wb(sadc_pkg::IDX_CTRL_ZERO, 1'b1, 32'h0002, 4'h3);
        rd(sadc_pkg::IDX_CTRL_ZERO, 4'h3, 32'h0002);
        // Empty selection: active, no result, run stays set
        wb(sadc_pkg::IDX_CHAN_SEL, 1'b1, 32'h00, 4'h1);
        wb(sadc_pkg::IDX_CTRL_ONE, 1'b1, 32'h01, 4'h1);
        repeat (8) @(posedge clk_i);
        rd(sadc_pkg::IDX_CTRL_ONE, 4'h1, 32'h01);
        rd(sadc_pkg::IDX_IRQ_STATUS, 4'h1, 32'h00);
        wb(sadc_pkg::IDX_CTRL_ONE, 1'b1, 32'h00, 4'h1);
        rd(sadc_pkg::IDX_RES0_HIGH, 4'h1, {24'h0, v0[11:4]});
        repeat (2) @(posedge clk_i);
        tally_and_finish();
    end
endmodule
`default_nettype wire
